// ==== logic/irb_reader.sv ====
// Id ROM byte reader: version and access registers over AXI4-Lite, byte fetch sequencer
`timescale 1ns/1ps
`include "irb_map.svh"

// Contract
// - Bit 24 of version shows memory presence
// - Present memory loads node block after reset
// - Version bits 31-25, 15-8 read zero
// - Version major field reads 01h
// - Version minor field reads 10h
// - Bit 31 clears address; device clears bit
// - Address clear never fetches byte zero
// - Writing bit 25 starts current byte read
// - Device clears bit 25 after fetch
// - Fetched byte appears in bits 23-16
// - Access bits 30-26, 24, 15-8 read zero
// - Option pointer reads zero by default
// - Byte 6h bit 5 makes pointer 20h
module irb_reader
  import irb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire irb_axi_req_t axi_req,
  output irb_axi_rsp_t axi_rsp,
  input wire logic id_memory_present_pin,
  output irb_fetch_req_t fetch_req,
  input wire irb_fetch_rsp_t fetch_rsp,
  output irb_boot_t boot_out
);

  // Registered state and its next value
  irb_state_s_t s;
  irb_state_s_t next_s;

  // Bus handshakes, taken in the same cycle for address and data
  logic wr_take;
  logic rd_take;
  logic wr_is_version;
  logic wr_is_access;
  logic rd_is_version;
  logic rd_is_access;
  logic set_clr;
  logic set_launch;
  logic fetch_done;
  logic [31:0] version_word;
  logic [31:0] access_word;

  // Write waits for both channels so the two never split
  assign wr_take = axi_req.awvalid && axi_req.wvalid && !s.bvalid;
  // One read outstanding at a time
  assign rd_take = axi_req.arvalid && !s.rvalid;
  assign wr_is_version = ({axi_req.awaddr[31:2], 2'b00} == `IRB_OFF_VERSION);
  assign wr_is_access = ({axi_req.awaddr[31:2], 2'b00} == `IRB_OFF_ACCESS);
  assign rd_is_version = ({axi_req.araddr[31:2], 2'b00} == `IRB_OFF_VERSION);
  assign rd_is_access = ({axi_req.araddr[31:2], 2'b00} == `IRB_OFF_ACCESS);

  // Self-clearing bits only react to ones in the top byte lane
  assign set_clr = wr_take && wr_is_access && axi_req.wstrb[3]
                   && axi_req.wdata[`IRB_BIT_ADDR_CLR];
  assign set_launch = wr_take && wr_is_access && axi_req.wstrb[3]
                      && axi_req.wdata[`IRB_BIT_LAUNCH];
  assign fetch_done = (s.st == ST_FETCH) && fetch_rsp.ack;

  // Version word: constant fields plus the synchronised presence level
  assign version_word = {7'h00, s.sync2, `IRB_VER_MAJOR, 8'h00, `IRB_VER_MINOR};

  // Access word: reserved bits tied low
  assign access_word = {s.addr_clr, 5'h00, s.launch, 1'b0, s.fetched_byte, 8'h00,
                        (s.opt_image ? `IRB_OPT_PTR : `IRB_OPT_NONE)};

  // Ready outputs combinational, valid outputs and data from flip-flops
  // One driver per struct port, so no tool has to split a variable
  assign axi_rsp = '{
    awready: wr_take,
    wready: wr_take,
    bvalid: s.bvalid,
    bresp: s.bresp,
    arready: rd_take,
    rvalid: s.rvalid,
    rdata: s.rdata,
    rresp: s.rresp
  };
  // Fetch link straight from the registered request
  assign fetch_req = '{
    req: s.rom_req,
    addr: s.rom_addr
  };
  // Boot stream, every field registered
  assign boot_out = '{
    strobe: s.boot_strobe,
    index: s.boot_index,
    data: s.boot_data,
    done: s.boot_done
  };

  // Next state of the whole block
  always_comb begin
    next_s = s;
    next_s.boot_strobe = 1'b0;
    // Presence pin synchroniser, first stage read only by the second
    next_s.sync1 = id_memory_present_pin;
    next_s.sync2 = s.sync1;

    // Write response
    if (s.bvalid && axi_req.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wr_take) begin
      next_s.bvalid = 1'b1;
      // Version register is read-only; writes to it are accepted and dropped
      next_s.bresp = (wr_is_version || wr_is_access) ? `IRB_RESP_OKAY : `IRB_RESP_DECERR;
    end

    // Read response, no side effects on either register
    if (s.rvalid && axi_req.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rd_take) begin
      next_s.rvalid = 1'b1;
      if (rd_is_version) begin
        next_s.rdata = version_word;
        next_s.rresp = `IRB_RESP_OKAY;
      end else if (rd_is_access) begin
        next_s.rdata = access_word;
        next_s.rresp = `IRB_RESP_OKAY;
      end else begin
        next_s.rdata = 32'h0000_0000;
        next_s.rresp = `IRB_RESP_DECERR;
      end
    end

    // Fetch sequencer
    unique case (s.st)
      // Presence is only trusted once the synchroniser has filled
      ST_SETTLE: begin
        if (s.settle_cnt == `IRB_SETTLE_CYCLES) begin
          if (s.sync2) begin
            next_s.st = ST_BOOT;
            next_s.boot_idx = 8'h00;
          end else begin
            // No memory: nothing to load
            next_s.st = ST_IDLE;
            next_s.boot_done = 1'b1;
          end
        end else begin
          next_s.settle_cnt = s.settle_cnt + 2'd1;
        end
      end
      // Issue the next node information byte
      ST_BOOT: begin
        next_s.rom_req = 1'b1;
        next_s.rom_addr = s.boot_idx;
        next_s.boot = 1'b1;
        next_s.st = ST_FETCH;
      end
      // Address clear first, then a pending read
      ST_IDLE: begin
        if (s.addr_clr) begin
          // Only the pointer moves; the data field is left alone
          next_s.mem_addr = 8'h00;
          next_s.addr_clr = 1'b0;
        end else if (s.launch) begin
          if (s.sync2) begin
            next_s.rom_req = 1'b1;
            next_s.rom_addr = s.mem_addr;
            next_s.boot = 1'b0;
            next_s.st = ST_FETCH;
          end else begin
            // Memory absent: finish at once so polling software never hangs
            next_s.launch = 1'b0;
          end
        end
      end
      // Request held until the engine answers
      ST_FETCH: begin
        if (fetch_rsp.ack) begin
          next_s.rom_req = 1'b0;
          // Option pointer follows bit 5 of byte 6h whenever that byte passes
          if (s.rom_addr == `IRB_OPT_OFFSET) begin
            next_s.opt_image = fetch_rsp.data[`IRB_OPT_BIT];
          end
          if (s.boot) begin
            next_s.boot_strobe = 1'b1;
            next_s.boot_data = fetch_rsp.data;
            next_s.boot_index = s.boot_idx;
            next_s.boot_idx = s.boot_idx + 8'h01;
            if (s.boot_idx == (`IRB_BOOT_BYTES - 8'h01)) begin
              next_s.boot_done = 1'b1;
              next_s.st = ST_IDLE;
            end else begin
              next_s.st = ST_BOOT;
            end
          end else begin
            next_s.fetched_byte = fetch_rsp.data;
            next_s.mem_addr = s.mem_addr + 8'h01;
            next_s.launch = 1'b0;
            next_s.st = ST_IDLE;
          end
        end
      end
    endcase

    // Software sets last, so a set in the clearing cycle wins
    if (set_clr) begin
      next_s.addr_clr = 1'b1;
    end
    if (set_launch) begin
      next_s.launch = 1'b1;
    end
  end

  // State register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.st <= ST_SETTLE;
    end else begin
      s <= next_s;
    end
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Settle finished with memory present
  sequence seq_settled_present;
    (s.st == ST_SETTLE) && (s.settle_cnt == `IRB_SETTLE_CYCLES) && s.sync2;
  endsequence

  // First boot request follows
  sequence seq_boot_request;
    (s.st == ST_BOOT) ##1 (s.rom_req && (s.rom_addr == s.boot_idx));
  endsequence

  // Software read fetch completes
  sequence seq_read_done;
    fetch_done && !s.boot;
  endsequence

  // Last node information byte answered
  sequence seq_boot_last;
    fetch_done && s.boot && (s.boot_idx == (`IRB_BOOT_BYTES - 8'h01));
  endsequence

  // Load begins once a present memory is seen
  a_boot_autoload: assert property (seq_settled_present |=> seq_boot_request)
    else $error("boot load did not start after reset");

  // Absent memory skips the load altogether
  a_boot_absent: assert property (
      (s.st == ST_SETTLE) && (s.settle_cnt == `IRB_SETTLE_CYCLES) && !s.sync2
      |=> (s.st == ST_IDLE) && s.boot_done && !s.rom_req)
    else $error("load started without memory");

  // Every answered boot byte is streamed out once
  a_boot_stream: assert property (fetch_done && s.boot
      |=> s.boot_strobe && (s.boot_data == $past(fetch_rsp.data))
      && (s.boot_index == $past(s.boot_idx)))
    else $error("boot byte not streamed");

  // Load stops after the last block byte
  a_boot_length: assert property (seq_boot_last
      |=> s.boot_done && (s.st == ST_IDLE))
    else $error("boot load length wrong");

  // Presence bit is the synchronised pin level
  a_version_present: assert property (rd_take && rd_is_version
      |=> s.rvalid && (s.rdata[`IRB_BIT_PRESENT] == $past(s.sync2)))
    else $error("presence bit does not follow memory detect");

  // Reserved version bits stay low
  a_version_zeros: assert property (rd_take && rd_is_version
      |=> (s.rdata[31:25] == 7'h00) && (s.rdata[15:8] == 8'h00))
    else $error("version reserved bits not zero");

  // Major field is a constant
  a_version_major: assert property (rd_take && rd_is_version
      |=> s.rdata[23:16] == `IRB_VER_MAJOR)
    else $error("major version field wrong");

  // Minor field is a constant
  a_version_minor: assert property (rd_take && rd_is_version
      |=> s.rdata[7:0] == `IRB_VER_MINOR)
    else $error("minor version field wrong");

  // Software ones land in the self-clearing bits
  a_clr_set: assert property (set_clr |=> s.addr_clr)
    else $error("address clear bit not set");

  a_launch_set: assert property (set_launch |=> s.launch)
    else $error("read start bit not set");

  // A zero in the start bit never launches a read
  a_zero_write: assert property (wr_take && wr_is_access
      && !axi_req.wdata[`IRB_BIT_LAUNCH] && !s.launch |=> !s.launch)
    else $error("zero write started a read");

  // Clear finishes in one idle cycle
  a_clr_completes: assert property ((s.st == ST_IDLE) && s.addr_clr && !set_clr
      |=> !s.addr_clr && (s.mem_addr == 8'h00))
    else $error("address clear did not complete");

  // Clear leaves the data field and the link alone
  a_clr_no_fetch: assert property ((s.st == ST_IDLE) && s.addr_clr
      |=> $stable(s.fetched_byte) && !s.rom_req)
    else $error("address clear touched read data");

  // Start fetches the byte at the current address
  a_launch_fetch: assert property ((s.st == ST_IDLE) && !s.addr_clr
      && s.launch && s.sync2
      |=> s.rom_req && (s.rom_addr == $past(s.mem_addr)))
    else $error("read start did not fetch current byte");

  // Request and address stand until the answer
  a_fetch_hold: assert property (s.rom_req && !fetch_rsp.ack
      |=> s.rom_req && $stable(s.rom_addr))
    else $error("fetch request dropped early");

  // Start bit drops with the answer unless set again
  a_launch_clears: assert property ((seq_read_done and (!set_launch))
      |=> !s.launch)
    else $error("read start bit not cleared");

  // Answered byte goes to the data field
  a_data_capture: assert property (seq_read_done
      |=> s.fetched_byte == $past(fetch_rsp.data))
    else $error("fetched byte not captured");

  // Read word carries the last fetched byte
  a_access_data: assert property (rd_take && rd_is_access
      |=> s.rdata[23:16] == $past(s.fetched_byte))
    else $error("access data field wrong");

  // Reserved access bits stay low
  a_access_zeros: assert property (rd_take && rd_is_access
      |=> (s.rdata[30:26] == 5'h00) && !s.rdata[24] && (s.rdata[15:8] == 8'h00))
    else $error("access reserved bits not zero");

  // Pointer reads zero or the image offset
  a_option_ptr: assert property (rd_take && rd_is_access
      |=> s.rdata[7:0] == ($past(s.opt_image) ? `IRB_OPT_PTR : `IRB_OPT_NONE))
    else $error("option pointer wrong");

  // Pointer flag taken from bit 5 of byte 6h
  a_opt_capture: assert property (fetch_done && (s.rom_addr == `IRB_OPT_OFFSET)
      |=> s.opt_image == $past(fetch_rsp.data[`IRB_OPT_BIT]))
    else $error("option flag not captured");

  // Each software read moves the address on
  a_addr_step: assert property (seq_read_done
      |=> s.mem_addr == $past(s.mem_addr) + 8'h01)
    else $error("address did not advance");

endmodule

// ==== logic/irb_map.svh ====
// Register offsets, field positions, constants and timing counts of the id ROM byte reader
`ifndef IRB_MAP_SVH
`define IRB_MAP_SVH

// Register byte addresses
`define IRB_OFF_VERSION 32'h0000_0000
`define IRB_OFF_ACCESS 32'h0000_0004

// Interface version register fields
`define IRB_VER_MAJOR 8'h01
`define IRB_VER_MINOR 8'h10
`define IRB_BIT_PRESENT 24

// Access register fields
`define IRB_BIT_ADDR_CLR 31
`define IRB_BIT_LAUNCH 25
`define IRB_DATA_LSB 16

// Option image pointer source: bit 5 of memory byte 6h
`define IRB_OPT_OFFSET 8'h06
`define IRB_OPT_BIT 5
`define IRB_OPT_PTR 8'h20
`define IRB_OPT_NONE 8'h00

// Node information block length loaded after reset
`define IRB_BOOT_BYTES 8'h14

// Cycles to let the presence synchroniser settle after reset
`define IRB_SETTLE_CYCLES 2'd2

// AXI responses
`define IRB_RESP_OKAY 2'b00
`define IRB_RESP_DECERR 2'b11

`endif

// ==== logic/irb_pkg.sv ====
// Types shared by the id ROM byte reader
package irb_pkg;

  // Controller states
  typedef enum logic [1:0] {
    ST_SETTLE,
    ST_BOOT,
    ST_IDLE,
    ST_FETCH
  } irb_state_t;

  // AXI4-Lite master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } irb_axi_req_t;

  // AXI4-Lite slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } irb_axi_rsp_t;

  // Byte fetch request to the serial memory engine
  typedef struct packed {
    logic req;
    logic [7:0] addr;
  } irb_fetch_req_t;

  // Byte fetch answer from the serial memory engine
  typedef struct packed {
    logic ack;
    logic [7:0] data;
  } irb_fetch_rsp_t;

  // Node information bytes streamed out after reset
  typedef struct packed {
    logic strobe;
    logic [7:0] index;
    logic [7:0] data;
    logic done;
  } irb_boot_t;

  // Whole state of the reader
  typedef struct packed {
    irb_state_t st;
    logic sync1;
    logic sync2;
    logic [1:0] settle_cnt;
    logic boot;
    logic [7:0] boot_idx;
    logic [7:0] mem_addr;
    logic addr_clr;
    logic launch;
    logic [7:0] fetched_byte;
    logic opt_image;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rom_req;
    logic [7:0] rom_addr;
    logic boot_strobe;
    logic [7:0] boot_data;
    logic [7:0] boot_index;
    logic boot_done;
  } irb_state_s_t;

endpackage

// ==== tb/irb_mem_model.sv ====
// Behavioural serial memory engine answering byte fetches
`timescale 1ns/1ps
module irb_mem_model
  import irb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire irb_fetch_req_t fetch_req,
  output irb_fetch_rsp_t fetch_rsp
);
  // Cycles spent before the answer
  logic [2:0] delay_cnt;

  // Answers promptly or after a stall; data toggles off the ack cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      delay_cnt <= 3'h0;
      fetch_rsp.ack <= 1'b0;
      fetch_rsp.data <= 8'h5a;
    end else if (!fetch_req.req || fetch_rsp.ack) begin
      // Idle or just answered: no stale byte left on the lines
      delay_cnt <= 3'h0;
      fetch_rsp.ack <= 1'b0;
      fetch_rsp.data <= ~fetch_rsp.data;
    end else if (delay_cnt == (slow ? 3'h6 : 3'h0)) begin
      // Contents are offset plus 30h, so byte 6h has bit 5 set
      fetch_rsp.ack <= 1'b1;
      fetch_rsp.data <= fetch_req.addr + 8'h30;
    end else begin
      delay_cnt <= delay_cnt + 3'h1;
      fetch_rsp.data <= ~fetch_rsp.data;
    end
  end
endmodule

// ==== tb/id_rom_byte_reader_test.sv ====
// Self-checking bench for the id ROM byte reader
`timescale 1ns/1ps
`include "irb_map.svh"
module id_rom_byte_reader_test
  import irb_pkg::*;
;
  logic aclk;
  logic aresetn;
  logic present; // Presence pin level
  logic slow; // Memory stall select
  irb_axi_req_t req;
  irb_axi_rsp_t rsp;
  irb_fetch_req_t fetch_req;
  irb_fetch_rsp_t fetch_rsp;
  irb_boot_t boot;
  int failures;
  int samples_checked;
  logic [31:0] rd_data; // Last read word
  logic [1:0] resp; // Last response code
  logic ok;

  irb_reader u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .axi_req(req),
    .axi_rsp(rsp),
    .id_memory_present_pin(present),
    .fetch_req(fetch_req),
    .fetch_rsp(fetch_rsp),
    .boot_out(boot)
  );

  irb_mem_model u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .slow(slow),
    .fetch_req(fetch_req),
    .fetch_rsp(fetch_rsp)
  );

  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Counts a comparison, reports a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for one channel handshake; the value before the edge is what counts
  task automatic hs(input int k);
    ok = 1'b0;
    while (ok !== 1'b1) begin
      @(negedge aclk);
      ok = (k == 0) ? rsp.awready : (k == 1) ? rsp.bvalid : (k == 2) ? rsp.arready : rsp.rvalid;
      resp = (k == 1) ? rsp.bresp : rsp.rresp;
      rd_data = rsp.rdata;
      @(posedge aclk);
    end
  endtask

  // Write word; address and data offered together
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    hs(0);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    hs(1);
  endtask

  // Read word into rd_data and resp
  task automatic rd(input logic [31:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    hs(2);
    req.arvalid <= 1'b0;
    hs(3);
  endtask

  // Reset held three cycles
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Start a byte read, poll until done, check the word
  task automatic launch_get(input logic [7:0] b);
    rd(`IRB_OFF_VERSION);
    chk({31'h0, rd_data[`IRB_BIT_PRESENT]}, 32'h0000_0001);
    wr(`IRB_OFF_ACCESS, 32'h0200_0000);
    rd(`IRB_OFF_ACCESS);
    while (rd_data[25] !== 1'b0) rd(`IRB_OFF_ACCESS);
    chk(rd_data, {8'h00, b, 8'h00, 8'h20});
  endtask

  // No memory: presence low, pointer zero
  task automatic t_absent;
    present <= 1'b0;
    do_reset();
    rd(`IRB_OFF_VERSION);
    chk(rd_data, 32'h0001_0010);
    rd(`IRB_OFF_ACCESS);
    chk(rd_data, 32'h0000_0000);
  endtask

  // Memory present: node block streamed after reset
  task automatic t_boot;
    int n;
    n = 0;
    present <= 1'b1;
    do_reset();
    while (boot.done !== 1'b1) begin
      @(negedge aclk);
      if (boot.strobe === 1'b1) begin
        chk({16'h0, boot.index, boot.data}, {16'h0, n[7:0], n[7:0] + 8'h30});
        n++;
      end
    end
    @(posedge aclk);
    chk(n, 32'd20);
    rd(`IRB_OFF_VERSION);
    chk(rd_data, 32'h0101_0010);
  endtask

  // Software byte reads, address clear, stalled memory
  task automatic t_fetch;
    wr(`IRB_OFF_ACCESS, 32'h8000_0000);
    launch_get(8'h30);
    launch_get(8'h31);
    slow <= 1'b1;
    launch_get(8'h32);
    wr(`IRB_OFF_ACCESS, 32'h8000_0000);
    rd(`IRB_OFF_ACCESS);
    chk(rd_data, 32'h0032_0020);
    wr(`IRB_OFF_ACCESS, 32'h0000_0000);
    rd(`IRB_OFF_ACCESS);
    chk(rd_data, 32'h0032_0020);
    slow <= 1'b0;
    launch_get(8'h30);
  endtask

  // Unmapped address and read-only version
  task automatic t_bus;
    rd(32'h0000_0008);
    chk({rd_data[31:2], resp}, {30'h0, `IRB_RESP_DECERR});
    wr(`IRB_OFF_VERSION, 32'hffff_ffff);
    chk({30'h0, resp}, {30'h0, `IRB_RESP_OKAY});
    rd(`IRB_OFF_VERSION);
    chk(rd_data, 32'h0101_0010);
  endtask

  // Prints counts and the verdict, then stops
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence; response readies held high throughout
  initial begin
    slow = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    failures = 0;
    samples_checked = 0;
    t_absent();
    t_boot();
    t_fetch();
    t_bus();
    give_verdict();
  end

  // Watchdog far beyond the expected run length
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    give_verdict();
  end
endmodule
